// ### lcdcbp_pkg.sv
// constants and types for the control byte parser of the display driver
// assumes nothing beyond a tool that reads packages before modules
package lcdcbp_pkg;
	localparam int unsigned LCDCBP_CONT_BIT  = 7;     // continue flag position
	localparam int unsigned LCDCBP_RSEL_BIT  = 6;     // register select position
	localparam int unsigned LCDCBP_DEPTH     = 80;    // display words per device
	localparam int unsigned LCDCBP_PTR_W     = 7;     // data pointer width
	localparam int unsigned LCDCBP_SUB_W     = 3;     // subaddress width
	localparam logic [6:0]  LCDCBP_PTR_RST   = 7'h00; // pointer after reset
	localparam logic [2:0]  LCDCBP_SUB_RST   = 3'h0;  // subaddress after reset
	localparam int unsigned LCDCBP_WORD_W    = 19;    // crossing word width

	// parser states
	typedef enum logic [1:0] {
		LCDCBP_IDLE = 2'b00,  // not addressed
		LCDCBP_CTRL = 2'b01,  // next byte is a control byte
		LCDCBP_ONE  = 2'b10,  // one payload byte, then control again
		LCDCBP_ALL  = 2'b11   // payload until stop or restart
	} lcdcbp_state_t;
endpackage

// ### lcdcbp_rx_cross.sv
// system clock side of the parsed byte crossing
// assumes the word is held stable for at least six clk cycles around a toggle
`timescale 1ns/1ps
module lcdcbp_rx_cross #(
	parameter int unsigned WORD_W = lcdcbp_pkg::LCDCBP_WORD_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              tog_in,
	input  wire logic [WORD_W-1:0] word_in,
	output logic                   valid_q,
	output logic [WORD_W-1:0]      word_q
);
	logic       s1_q;   // first stage, read only by s2
	logic       s2_q;   // second stage
	logic       s3_q;   // third stage
	logic       seen_q; // last toggle level taken
	logic       take;   // new event, stages agree

	// toggle synchroniser, three stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= tog_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stage two and three agree
	assign take = (s2_q == s3_q) && (s3_q != seen_q);

	// capture the word, pulse valid for one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q  <= 1'b0;
			valid_q <= 1'b0;
			word_q  <= '0;
		end else begin
			valid_q <= take;
			if (take) begin
				seen_q <= s3_q;
				word_q <= word_in;
			end
		end
	end

	valid_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		valid_q |=> !valid_q)
		else $error("valid held longer than one cycle");
endmodule

// ### lcdcbp_top.sv
// control byte parser behind the two-wire serial slave of a display driver
// assumes a bit level front end on link_clk giving one pulse per byte
// after the address acknowledge, and pulses for start match and stop
`timescale 1ns/1ps
module lcdcbp_top #(
	parameter int unsigned DEPTH = lcdcbp_pkg::LCDCBP_DEPTH
) (
	input  wire logic                              clk,
	input  wire logic                              resetn,
	input  wire logic                              link_clk,
	input  wire logic                              lnk_start,
	input  wire logic                              lnk_end,
	input  wire logic                              lnk_byte_valid,
	input  wire logic [7:0]                        lnk_byte,
	input  wire logic                              subaddr_pin_bit0,
	input  wire logic                              subaddr_pin_bit1,
	input  wire logic                              subaddr_pin_bit2,
	output logic                                   lnk_ack_q,
	output logic                                   lnk_ack_valid_q,
	output logic                                   out_valid_q,
	output logic                                   out_is_cmd_q,
	output logic [7:0]                             out_byte_q,
	output logic [lcdcbp_pkg::LCDCBP_PTR_W-1:0]    out_ptr_q,
	output logic [lcdcbp_pkg::LCDCBP_SUB_W-1:0]    out_sub_q
);
	localparam int unsigned PW = lcdcbp_pkg::LCDCBP_PTR_W;
	localparam int unsigned SW = lcdcbp_pkg::LCDCBP_SUB_W;
	localparam int unsigned WW = lcdcbp_pkg::LCDCBP_WORD_W;
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	// refuse a depth the pointer cannot hold, at elaboration
	if (DEPTH < 2 || DEPTH > (1 << PW)) begin : g_depth_chk
		$error("DEPTH out of range for pointer width");
	end

	logic                      lrst1_q;   // link reset stage one
	logic                      lrst_n_q;  // link domain reset
	logic                      crst1_q;   // clk reset stage one
	logic                      crst_n_q;  // clk domain reset
	logic [SW-1:0]             pin1_q;    // pin stage one, read by stage two only
	logic [SW-1:0]             pin2_q;    // pin stage two
	logic [SW-1:0]             pin3_q;    // pin stage three
	logic [SW-1:0]             pins_q;    // filtered subaddress pins
	lcdcbp_pkg::lcdcbp_state_t state_q;   // parser state
	lcdcbp_pkg::lcdcbp_state_t state_d;
	logic                      rsel_q;    // data register chosen
	logic [PW-1:0]             ptr_q;     // data pointer
	logic [SW-1:0]             sub_q;     // subaddress counter
	logic                      is_ctrl;   // this byte is a control byte
	logic                      is_pay;    // this byte is command or data
	logic                      is_data;   // payload to display memory
	logic                      match;     // our subaddress is current
	logic                      ack_d;     // ack decision for this byte
	logic                      tog_q;     // crossing event toggle
	logic [WW-1:0]             word_q;    // crossing word, held between bytes

	// reset release, two stages per domain
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			lrst1_q  <= 1'b0;
			lrst_n_q <= 1'b0;
		end else begin
			lrst1_q  <= 1'b1;
			lrst_n_q <= lrst1_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crst1_q  <= 1'b0;
			crst_n_q <= 1'b0;
		end else begin
			crst1_q  <= 1'b1;
			crst_n_q <= crst1_q;
		end
	end

	// subaddress pins, three stages, change taken once two and three agree
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			pin1_q <= '0;
			pin2_q <= '0;
			pin3_q <= '0;
			pins_q <= '0;
		end else begin
			pin1_q <= {subaddr_pin_bit2, subaddr_pin_bit1, subaddr_pin_bit0};
			pin2_q <= pin1_q;
			pin3_q <= pin2_q;
			if (pin2_q == pin3_q)
				pins_q <= pin3_q;
		end
	end

	// byte classification from parser state
	always_comb begin
		is_ctrl = lnk_byte_valid && (state_q == lcdcbp_pkg::LCDCBP_CTRL);
		is_pay  = lnk_byte_valid && (state_q == lcdcbp_pkg::LCDCBP_ONE ||
			state_q == lcdcbp_pkg::LCDCBP_ALL);
		is_data = is_pay && rsel_q;
		match   = (sub_q == pins_q);
		ack_d   = is_ctrl || (is_pay && !rsel_q) || (is_data && match);
	end

	// next state of the parser
	always_comb begin
		state_d = state_q;
		if (lnk_end) begin
			state_d = lcdcbp_pkg::LCDCBP_IDLE;
		end else if (lnk_start) begin
			state_d = lcdcbp_pkg::LCDCBP_CTRL;
		end else if (is_ctrl) begin
			if (lnk_byte[lcdcbp_pkg::LCDCBP_CONT_BIT])
				state_d = lcdcbp_pkg::LCDCBP_ONE;
			else
				state_d = lcdcbp_pkg::LCDCBP_ALL;
		end else if (is_pay && state_q == lcdcbp_pkg::LCDCBP_ONE) begin
			state_d = lcdcbp_pkg::LCDCBP_CTRL;
		end
		// stay in payload: ALL holds until end or start
	end

	// parser state and register select
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			state_q <= lcdcbp_pkg::LCDCBP_IDLE;
			rsel_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			// bit six selects, low bits unused
			if (is_ctrl && !lnk_end && !lnk_start)
				rsel_q <= lnk_byte[lcdcbp_pkg::LCDCBP_RSEL_BIT];
		end
	end

	// acknowledge decision, one cycle after the byte
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			lnk_ack_q       <= 1'b0;
			lnk_ack_valid_q <= 1'b0;
		end else begin
			lnk_ack_valid_q <= lnk_byte_valid;
			lnk_ack_q       <= ack_d;
		end
	end

	// pointer advances on every display byte and subaddress on each pointer wrap, matched or not,
	// so all cascaded devices keep the same count
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			ptr_q <= lcdcbp_pkg::LCDCBP_PTR_RST;
			sub_q <= lcdcbp_pkg::LCDCBP_SUB_RST;
		end else if (is_data && !lnk_end && !lnk_start) begin
			if (ptr_q == PTR_LAST) begin
				ptr_q <= '0;
				sub_q <= sub_q + SW'(1);
			end else begin
				ptr_q <= ptr_q + PW'(1);
			end
		end
	end

	// launch commands and matched display bytes across to clk
	always_ff @(posedge link_clk or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			tog_q  <= 1'b0;
			word_q <= '0;
		end else if (is_pay && !lnk_end && !lnk_start && (!rsel_q || match)) begin
			tog_q  <= ~tog_q;
			word_q <= {!rsel_q, lnk_byte, ptr_q, sub_q};
		end
	end

	logic [WW-1:0] rx_word; // word as taken on clk

	// clk side capture; word stays put until the next byte, which is
	// many link cycles later at any legal bus rate
	lcdcbp_rx_cross #(
		.WORD_W (WW)
	) u_cross (
		.clk     (clk),
		.rst_n   (crst_n_q),
		.tog_in  (tog_q),
		.word_in (word_q),
		.valid_q (out_valid_q),
		.word_q  (rx_word)
	);

	always_comb begin
		out_is_cmd_q = rx_word[WW-1];
		out_byte_q   = rx_word[WW-2 -: 8];
		out_ptr_q    = rx_word[SW +: PW];
		out_sub_q    = rx_word[SW-1:0];
	end

	ctrl_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_ctrl |=> lnk_ack_q && lnk_ack_valid_q)
		else $error("control byte not acknowledged");
	data_ack_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_data && !match |=> !lnk_ack_q)
		else $error("display byte acked with wrong subaddress");
	first_ctrl_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		lnk_start && !lnk_end |=> state_q == lcdcbp_pkg::LCDCBP_CTRL)
		else $error("no control state after address");
	cont_one_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_pay && state_q == lcdcbp_pkg::LCDCBP_ONE && !lnk_start && !lnk_end
		|=> state_q == lcdcbp_pkg::LCDCBP_CTRL)
		else $error("no control byte after single payload");
	last_ctrl_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_ctrl && !lnk_start && !lnk_end && !lnk_byte[7]
		|=> state_q == lcdcbp_pkg::LCDCBP_ALL)
		else $error("last control byte did not open payload");
	rsel_take_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_ctrl && !lnk_start && !lnk_end |=> rsel_q == $past(lnk_byte[6]))
		else $error("register select not taken");
	ptr_step_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_data && !lnk_start && !lnk_end && ptr_q != PTR_LAST
		|=> ptr_q == $past(ptr_q) + PW'(1) && sub_q == $past(sub_q))
		else $error("pointer did not advance");
	store_word_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		is_data && match && !lnk_start && !lnk_end
		|=> word_q[SW-1:0] == $past(sub_q) && word_q[SW +: PW] == $past(ptr_q))
		else $error("display byte launched with wrong location");
	end_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
		state_q == lcdcbp_pkg::LCDCBP_IDLE && lnk_byte_valid && !lnk_start |=> !lnk_ack_q)
		else $error("byte acked after stop");
endmodule

// ### lcdcbp_master_model.sv
// bus master model on the parsed link side of the control byte parser
// assumes link_clk from the bench; all outputs change on falling edges
`timescale 1ns/1ps
module lcdcbp_master_model (
	input  wire logic       link_clk,
	input  wire logic       ack_q,
	input  wire logic       ack_valid_q,
	output logic            start,
	output logic            stop,
	output logic            byte_valid,
	output logic [7:0]      data
);
	// quiet bus at time zero
	initial begin
		start = 1'b0;
		stop = 1'b0;
		byte_valid = 1'b0;
		data = 8'h00;
	end
	// address acknowledged, access opens
	task automatic open_access();
		@(negedge link_clk) start = 1'b1;
		@(negedge link_clk) start = 1'b0;
	endtask
	task automatic close_access();
		@(negedge link_clk) stop = 1'b1;
		@(negedge link_clk) stop = 1'b0;
	endtask
	// one byte of any kind first; answer taken one cycle later
	task automatic xfer(input logic [7:0] b, output logic a, output logic av);
		@(negedge link_clk) begin
			byte_valid = 1'b1;
			data = b;
		end
		@(negedge link_clk) begin
			byte_valid = 1'b0;
			data = ~b; // released: no stale value
		end
		a = ack_q;
		av = ack_valid_q;
		// spacing as nine bit times on the wire
		repeat (7) @(negedge link_clk);
	endtask
endmodule

// ### tb.sv
// self-checking bench for the control byte parser, depth cut to 4
// assumes the master model drives the link side; pins set on clk falls
`timescale 1ns/1ps
module tb;
	logic        clk, resetn, link_clk, st, en, bv, ack, ackv, ov, oc;
	logic [7:0]  bt, ob;
	logic [6:0]  op;
	logic [2:0]  os, pins;
	logic [18:0] q[$]; // seen words {cmd, byte, ptr, sub}
	int          n_mismatch = 0;
	int          n_tests = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// link clock unrelated in phase
	initial begin
		link_clk = 1'b0;
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	lcdcbp_top #(.DEPTH(4)) lcdcbp_top_i (.clk(clk), .resetn(resetn), .link_clk(link_clk),
		.lnk_start(st), .lnk_end(en), .lnk_byte_valid(bv), .lnk_byte(bt),
		.subaddr_pin_bit0(pins[0]), .subaddr_pin_bit1(pins[1]), .subaddr_pin_bit2(pins[2]),
		.lnk_ack_q(ack), .lnk_ack_valid_q(ackv), .out_valid_q(ov), .out_is_cmd_q(oc),
		.out_byte_q(ob), .out_ptr_q(op), .out_sub_q(os));
	lcdcbp_master_model lcdcbp_master_model_i (.link_clk(link_clk), .ack_q(ack),
		.ack_valid_q(ackv), .start(st), .stop(en), .byte_valid(bv), .data(bt));

	// collect every forwarded byte
	always @(negedge clk) begin
		if (ov === 1'b1) begin
			q.push_back({oc, ob, op, os});
		end
	end

	task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one byte: ack, forwarding and the stored word
	task automatic send(input logic [7:0] b, input logic ak, input logic fw,
			input logic cm, input logic [6:0] p, input logic [2:0] s);
		logic a, av;
		logic [18:0] w;
		lcdcbp_master_model_i.xfer(b, a, av);
		if (ak) chk({18'h0, av}, 19'h1);
		chk({18'h0, a}, {18'h0, ak});
		chk(19'(q.size()), {18'h0, fw});
		if (q.size() > 0) begin
			w = q.pop_front();
			// commands: ptr and sub fields not compared
			if (cm) chk({10'h0, w[18:10]}, {10'h0, 1'b1, b});
			else chk(w, {1'b0, b, p, s});
		end
	endtask

	task automatic t_data();
		lcdcbp_master_model_i.open_access();
		send(8'h40, 1'b1, 1'b0, 1'b0, 7'h00, 3'h0);
		send(8'h11, 1'b1, 1'b1, 1'b0, 7'h00, 3'h0);
		send(8'h22, 1'b1, 1'b1, 1'b0, 7'h01, 3'h0);
		send(8'h33, 1'b1, 1'b1, 1'b0, 7'h02, 3'h0);
		lcdcbp_master_model_i.close_access();
		$display("test data done");
	endtask

	// continued and last control bytes, ignored low bits set
	task automatic t_mixed();
		lcdcbp_master_model_i.open_access();
		send(8'h80, 1'b1, 1'b0, 1'b0, 7'h00, 3'h0);
		send(8'hA5, 1'b1, 1'b1, 1'b1, 7'h00, 3'h0);
		send(8'hFF, 1'b1, 1'b0, 1'b0, 7'h00, 3'h0);
		send(8'h44, 1'b1, 1'b1, 1'b0, 7'h03, 3'h0);
		send(8'h3F, 1'b1, 1'b0, 1'b0, 7'h00, 3'h0);
		send(8'h5A, 1'b1, 1'b1, 1'b1, 7'h00, 3'h0);
		send(8'hC3, 1'b1, 1'b1, 1'b1, 7'h00, 3'h0);
		lcdcbp_master_model_i.close_access();
		$display("test mixed done");
	endtask

	// pointer wrapped to subaddress 1; other device stays silent
	task automatic t_sub();
		lcdcbp_master_model_i.open_access();
		send(8'h40, 1'b1, 1'b0, 1'b0, 7'h00, 3'h0);
		send(8'h77, 1'b0, 1'b0, 1'b0, 7'h00, 3'h1);
		@(negedge clk) pins = 3'h1;
		// pin filter needs about four link cycles to take the change
		repeat (6) @(negedge link_clk);
		send(8'h88, 1'b1, 1'b1, 1'b0, 7'h01, 3'h1);
		lcdcbp_master_model_i.close_access();
		// idle after stop: ignored
		send(8'h40, 1'b0, 1'b0, 1'b0, 7'h00, 3'h0);
		$display("test subaddress done");
	endtask

	task automatic test_done();
		$display("counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		pins = 3'h0;
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		repeat (5) @(negedge link_clk);
		t_data();
		t_mixed();
		t_sub();
		test_done();
	end
endmodule
